// ### hw/sis_pkg.sv
// Shared constants and types for the serial interrupt slave frame control.
package sis_pkg;

	// Low widths, in clocks, that classify host pulses.
	localparam logic [3:0] SIS_START_MIN_LOW  = 4'h4;
	localparam logic [3:0] SIS_STOP_QUIET_LOW = 4'h2;
	localparam logic [3:0] SIS_STOP_CONT_LOW  = 4'h3;
	localparam logic [3:0] SIS_LOW_SAT        = 4'hf;

	// Frame timing after the rising edge of the start pulse.
	localparam int         SIS_FRAME_CLKS     = 3;
	localparam int         SIS_SAMPLE_OFS     = 2;
	localparam logic [7:0] SIS_CYC_SAT        = 8'hff;

	// Earliest clock after the stop pulse edge for a quiet-mode start.
	localparam logic [1:0] SIS_START_GAP      = 2'h2;
	localparam logic [1:0] SIS_GAP_SAT        = 2'h3;

	// Number of interrupt lines served; line i uses data frame i+1.
	localparam int         SIS_NUM_IRQ        = 16;

	typedef enum logic [1:0] {SIS_IDLE, SIS_START, SIS_FRAMES} sis_bus_t;

	typedef struct packed {
		logic oe;
		logic out;
	} sis_pin_t;

endpackage

// ### hw/sis_frame_ctrl.sv
// Slave side start-frame, data-frame and cycle-mode control for a serialized interrupt line.
`timescale 1ns/1ps
`default_nettype none

module sis_frame_ctrl
	import sis_pkg::*;
#(
	parameter int NUM_IRQ = SIS_NUM_IRQ
)(
	input  wire logic               i_clk_sys,
	input  wire logic               i_resetn,
	input  wire logic               i_host_bus_reset_low,
	input  wire logic [NUM_IRQ-1:0] i_irq_lines,
	input  wire logic               i_serirq_in,
	output var  logic               o_serirq_out,
	output var  logic               o_serirq_oe,
	output var  logic               o_quiet_mode,
	output var  logic               o_bus_active
);

	////////////////////////////////////////////////////////////////////////////
	// State.

	sis_bus_t     state;
	sis_bus_t     next_state;
	logic [3:0]   low_cnt;
	logic [3:0]   next_low_cnt;
	logic [7:0]   cyc;
	logic [7:0]   next_cyc;
	logic [1:0]   since_stop;
	logic [1:0]   next_since_stop;
	logic         quiet;
	logic         next_quiet;
	logic         active;
	logic         next_active;
	logic         data_low;
	logic         next_data_low;
	logic         own_start;
	logic         next_own_start;
	sis_pin_t     pin;
	sis_pin_t     next_pin;
	logic [NUM_IRQ-1:0] sent;
	logic [NUM_IRQ-1:0] next_sent;
	logic [NUM_IRQ-1:0] hit;
	logic         line_low;
	logic         rise;
	logic         is_start;
	logic         is_stop;
	logic         slot_low;

	// The line is sampled once per rising edge and is synchronous to the bus clock.
	assign line_low = !i_serirq_in;
	assign rise     = !line_low && (low_cnt != 4'h0);
	assign is_start = rise && (low_cnt >= SIS_START_MIN_LOW);
	assign is_stop  = rise && ((low_cnt == SIS_STOP_QUIET_LOW) ||
	                           (low_cnt == SIS_STOP_CONT_LOW));

	////////////////////////////////////////////////////////////////////////////
	// Sample slot decode: line i owns the clock 3(i+1)-1 after the start edge.

	genvar gi;
	generate
		for (gi = 0; gi < NUM_IRQ; gi++)
		begin : g_slot
			assign hit[gi] = (next_state == SIS_FRAMES) &&
			                 (next_cyc == 8'(SIS_FRAME_CLKS * gi + SIS_SAMPLE_OFS));
		end
	endgenerate

	assign slot_low = |(hit & ~i_irq_lines);

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb
	begin
		next_state      = state;
		next_low_cnt    = line_low ? ((low_cnt == SIS_LOW_SAT) ? low_cnt : low_cnt + 4'h1) : 4'h0;
		next_cyc        = (cyc == SIS_CYC_SAT) ? cyc : cyc + 8'h01;
		next_since_stop = (since_stop == SIS_GAP_SAT) ? since_stop : since_stop + 2'h1;
		next_quiet      = quiet;
		next_sent       = sent;
		next_own_start  = 1'b0;
		next_pin        = '0;
		next_data_low   = 1'b0;

		unique case (state)
			SIS_IDLE:
			begin
				// Idle lasts any number of clocks; a host low starts the cycle.
				if (line_low)
					next_state = SIS_START;
				else if (quiet && (since_stop >= SIS_START_GAP) && (i_irq_lines != sent))
				begin
					next_state     = SIS_START;
					next_own_start = 1'b1;
					next_pin       = '{oe: 1'b1, out: 1'b0};
				end
			end
			SIS_START:
			begin
				if (is_start)
				begin
					next_state = SIS_FRAMES;
					next_cyc   = 8'h01;
				end
				else if (is_stop)
				begin
					// A stop seen before any start frame still sets the mode of the next cycle.
					next_state      = SIS_IDLE;
					next_quiet      = (low_cnt == SIS_STOP_QUIET_LOW);
					next_since_stop = 2'h1;
				end
				else if (rise)
					next_state = SIS_IDLE;
			end
			SIS_FRAMES:
			begin
				if (is_start)
					next_cyc = 8'h01;
				else if (is_stop)
				begin
					next_state      = SIS_IDLE;
					next_quiet      = (low_cnt == SIS_STOP_QUIET_LOW);
					next_since_stop = 2'h1;
				end
			end
		endcase

		// A change whose slot is still ahead rides the running cycle instead of a new start.
		next_sent = (sent & ~hit) | (i_irq_lines & hit);
		if (slot_low)
		begin
			next_pin      = '{oe: 1'b1, out: 1'b0};
			next_data_low = 1'b1;
		end
		else if (data_low)
			next_pin = '{oe: 1'b1, out: 1'b1};

		next_active = (next_state != SIS_IDLE);

		if (!i_host_bus_reset_low)
		begin
			next_state      = SIS_IDLE;
			next_quiet      = 1'b0;
			next_pin        = '0;
			next_data_low   = 1'b0;
			next_own_start  = 1'b0;
			next_active     = 1'b0;
			next_low_cnt    = 4'h0;
			next_since_stop = SIS_GAP_SAT;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge i_clk_sys or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state      <= SIS_IDLE;
			low_cnt    <= 4'h0;
			cyc        <= SIS_CYC_SAT;
			since_stop <= SIS_GAP_SAT;
			quiet      <= 1'b0;
			active     <= 1'b0;
			data_low   <= 1'b0;
			own_start  <= 1'b0;
			pin        <= '0;
			sent       <= '1;
		end
		else
		begin
			state      <= next_state;
			low_cnt    <= next_low_cnt;
			cyc        <= next_cyc;
			since_stop <= next_since_stop;
			quiet      <= next_quiet;
			active     <= next_active;
			data_low   <= next_data_low;
			own_start  <= next_own_start;
			pin        <= next_pin;
			sent       <= next_sent;
		end
	end

	assign o_serirq_out = pin.out;
	assign o_serirq_oe  = pin.oe;
	assign o_quiet_mode = quiet;
	assign o_bus_active = active;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	AST_START_ONE_CLK: assert property (own_start |=> !pin.oe)
		else $error("Own start pulse longer than one clock.");
	AST_START_NO_HIGH: assert property (own_start |-> pin.oe && !pin.out ##1 !(pin.oe && pin.out))
		else $error("Line driven high after own start pulse.");
	AST_START_IDLE: assert property (own_start |-> $past(state) == SIS_IDLE)
		else $error("Own start issued during an active cycle.");
	AST_CONT_PASSIVE: assert property (own_start |-> $past(quiet))
		else $error("Own start issued in continuous mode.");
	AST_START_GAP: assert property (own_start |-> $past(since_stop) >= SIS_START_GAP)
		else $error("Own start too soon after stop pulse.");
	AST_MODE_AT_STOP: assert property ($changed(quiet) |-> $past(is_stop) || $past(!i_host_bus_reset_low))
		else $error("Mode changed outside a stop frame.");
	AST_STOP_QUIET: assert property (is_stop && low_cnt == 4'h2 && i_host_bus_reset_low |=> quiet)
		else $error("Two clock stop did not select quiet mode.");
	AST_STOP_CONT: assert property (is_stop && low_cnt == 4'h3 |=> !quiet)
		else $error("Three clock stop did not select continuous mode.");
	AST_SLOT_POS: assert property (state == SIS_FRAMES && pin.oe && !pin.out |-> cyc >= 8'h02 && (cyc % 8'h03) == 8'h02)
		else $error("Data frame low outside a sample clock.");
	AST_RECOVERY: assert property (state == SIS_FRAMES && pin.oe && !pin.out && i_host_bus_reset_low |=> pin.oe && pin.out ##1 !pin.oe)
		else $error("Recovery high or turnaround release missing.");
	AST_BUS_RESET: assert property (!i_host_bus_reset_low |=> !pin.oe && !quiet && !active)
		else $error("Bus reset did not release the line.");

	COV_OWN_START: cover property (own_start ##[1:12] is_start);
	COV_QUIET_STOP: cover property (is_stop && low_cnt == 4'h2);
	COV_CONT_STOP: cover property (is_stop && low_cnt == 4'h3);
	COV_DATA_LOW: cover property (data_low ##1 pin.oe && pin.out);

endmodule

`default_nettype wire

// ### test/sis_host_model.sv
// Behavioural host side of the serialized interrupt wire.
`timescale 1ns/1ps
`default_nettype none

module sis_host_model
	import sis_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_wire,
	output var  logic        o_oe,
	output var  logic        o_out,
	output var  logic [15:0] o_image
);

	initial
	begin
		o_oe = 1'b0;
		o_out = 1'b1;
		o_image = '1;
	end

	////////////////////////////////////////////////////////////////////////////
	// One whole cycle; own means the device has already given the first low clock.
	task automatic run_cycle(input int start_len, input int stop_len, input bit own);
		@(posedge i_clk_sys);
		o_oe <= 1'b1;
		o_out <= 1'b0;
		repeat (start_len - (own ? 1 : 0)) @(posedge i_clk_sys);
		o_out <= 1'b1;
		@(posedge i_clk_sys);
		o_oe <= 1'b0;
		@(posedge i_clk_sys);
		// Sampling on the falling edge reads the settled level of each sample clock.
		for (int i = 0; i < SIS_NUM_IRQ; i++)
		begin
			@(negedge i_clk_sys);
			o_image[i] = i_wire;
			repeat (2) @(negedge i_clk_sys);
		end
		@(posedge i_clk_sys);
		o_oe <= 1'b1;
		o_out <= 1'b0;
		repeat (stop_len) @(posedge i_clk_sys);
		o_out <= 1'b1;
		@(posedge i_clk_sys);
		o_oe <= 1'b0;
	endtask

endmodule

`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the serial interrupt frame control.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import sis_pkg::*;

	logic        clk, rst_n, bus_rst_n, serirq;
	logic        d_out, d_oe, quiet, active, h_oe, h_out;
	logic [15:0] irq, img;
	int          fails = 0;
	int          n_checks = 0;

	// The wire has a pull-up, so nobody driving reads high.
	assign serirq = d_oe ? d_out : (h_oe ? h_out : 1'b1);

	sis_frame_ctrl #(.NUM_IRQ(16)) dut_u (.i_clk_sys(clk), .i_resetn(rst_n),
		.i_host_bus_reset_low(bus_rst_n), .i_irq_lines(irq), .i_serirq_in(serirq),
		.o_serirq_out(d_out), .o_serirq_oe(d_oe), .o_quiet_mode(quiet), .o_bus_active(active));

	sis_host_model host_u (.i_clk_sys(clk), .i_wire(serirq), .o_oe(h_oe), .o_out(h_out), .o_image(img));

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp)
		begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		if (fails == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic t_cont();
		@(posedge clk);
		irq <= 16'ha5c3;
		repeat (20)
		begin
			@(negedge clk);
			check("serirq_oe", 16'h0, {15'h0, d_oe});
		end
		host_u.run_cycle(4, 3, 1'b0);
		check("image", 16'ha5c3, img);
		@(negedge clk);
		check("quiet_mode", 16'h0, {15'h0, quiet});
		check("bus_active", 16'h0, {15'h0, active});
	endtask

	task automatic t_quiet();
		int n;
		host_u.run_cycle(8, 2, 1'b0);
		repeat (6) @(negedge clk);
		check("quiet_mode", 16'h1, {15'h0, quiet});
		check("serirq_oe", 16'h0, {15'h0, d_oe});
		@(posedge clk);
		irq <= 16'h0ff0;
		n = 0;
		while (d_oe !== 1'b1 && n < 20)
		begin
			@(negedge clk);
			n++;
		end
		check("start_oe", 16'h1, {15'h0, d_oe});
		check("start_low", 16'h0, {15'h0, d_out});
		check("bus_active", 16'h1, {15'h0, active});
		fork
			host_u.run_cycle(5, 2, 1'b1);
		join_none
		@(negedge clk);
		check("serirq_oe", 16'h0, {15'h0, d_oe});
		wait fork;
		check("image", 16'h0ff0, img);
		// Next start follows the turnaround clock at once.
		host_u.run_cycle(4, 3, 1'b0);
		check("image", 16'h0ff0, img);
		@(negedge clk);
		check("quiet_mode", 16'h0, {15'h0, quiet});
	endtask

	task automatic t_bus_reset();
		host_u.run_cycle(4, 2, 1'b0);
		@(negedge clk);
		check("quiet_mode", 16'h1, {15'h0, quiet});
		@(posedge clk);
		bus_rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		bus_rst_n <= 1'b1;
		@(negedge clk);
		check("quiet_mode", 16'h0, {15'h0, quiet});
		check("serirq_oe", 16'h0, {15'h0, d_oe});
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		rst_n = 1'b0;
		bus_rst_n = 1'b1;
		irq = '1;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		check("quiet_mode", 16'h0, {15'h0, quiet});
		t_cont();
		t_quiet();
		t_bus_reset();
		finish_test();
	end

	// The scenarios need a few microseconds; this cuts a hang short.
	initial
	begin
		#200000;
		fails++;
		finish_test();
	end

endmodule

`default_nettype wire
